// File: core/reader_control_status_page.sv
// Functional notes
// - standby stops blocks, clock keeps running
// - deep sleep stops blocks and clock
// - cipher flag set only by auth success
// - timer halt strobe, reads zero
// - timer launch strobe, reads zero
// - queue purge clears pointers, level, overrun
// - read-only error flags, reset 40h
// - key fault clears at load, sets bad
// - nvm fault clears at start, sets violation
// - overrun sets on write while full
// - checksum fault when enabled and bad
// - frame start fault on bad start
// - parity fault on parity failure
// - collision fault, type A only
// - receive faults cleared in receive prepare
// - collision index gives first collision position
// - no collision index under type B
// - read-only timer count register
// - timer count read shows live counter
// - expiry flag sets at zero only
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module reader_control_status_page
(
   input  wire logic                          pclk,             // 125 MHz clock
   input  wire logic                          presetn,          // async reset, low
   input  wire logic                          psel,             // apb select
   input  wire logic                          penable,          // apb access phase
   input  wire logic                          pwrite,           // apb write
   input  wire logic [11:0]                   paddr,            // apb byte address
   input  wire logic [31:0]                   pwdata,           // apb write data
   output logic      [31:0]                   prdata,           // apb read data
   output logic                               pready,           // apb ready
   output logic                               pslverr,          // apb error
   input  wire reader_ctl_pkg::fault_events_t fault_events,     // command and rx events
   input  wire logic                          auth_second_ok,   // second auth passed
   input  wire logic                          receive_check_enable, // rx crc check on
   input  wire logic                          type_b_mode,      // type B protocol
   output reader_ctl_pkg::power_ctl_t         power_ctl,        // power requests
   output logic                               cipher_active,    // encrypt card traffic
   output logic                               queue_purge,      // flush queue pulse
   output logic                               timer_expiry_request // timer hit zero
);

   reader_ctl_pkg::apb_phase_t phase;
   reader_ctl_pkg::apb_phase_t next_phase;

   logic [7:0] ctl_hold;
   logic [1:0] sleep_bits;
   logic       cipher_bit;
   logic [7:0] coll_index;
   logic       coll_captured;
   logic [7:0] reload;
   logic [7:0] err_flags;
   logic [7:0] err_set;
   logic [7:0] err_clr;
   logic [7:0] timer_count;
   logic       timer_running;
   logic       timer_expired;
   logic       halt_pulse;
   logic       launch_pulse;
   logic [7:0] read_mux;
   logic       addr_hit;
   logic       wr_edge;
   logic       ctl_write;
   logic       reload_write;
   logic [9:0] word_addr;

   // register decode on the word address
   assign word_addr = paddr[11:2];

   always_comb
   begin
      addr_hit = 1'b1;
      read_mux = 8'h00;
      case (word_addr)
         {2'b00, reader_ctl_pkg::IDX_CONTROL}:
            read_mux = {2'b00, ctl_hold[5:3], 3'b000};
         {2'b00, reader_ctl_pkg::IDX_ERROR}:
            read_mux = err_flags;
         {2'b00, reader_ctl_pkg::IDX_COLL}:
            read_mux = coll_index;
         {2'b00, reader_ctl_pkg::IDX_TIMER}:
            read_mux = timer_count;
         {2'b00, reader_ctl_pkg::IDX_RELOAD}:
            read_mux = reload;
         {2'b00, reader_ctl_pkg::IDX_TSTAT}:
            read_mux = {6'h00, timer_running, timer_expired};
         default:
            addr_hit = 1'b0;
      endcase
   end

   // apb phase tracking
   always_comb
   begin
      next_phase = phase;
      case (phase)
         reader_ctl_pkg::PH_IDLE:
            if (psel)
               next_phase = reader_ctl_pkg::PH_SETUP;
         reader_ctl_pkg::PH_SETUP:
            if (psel && penable)
               next_phase = reader_ctl_pkg::PH_ACCESS;
            else if (!psel)
               next_phase = reader_ctl_pkg::PH_IDLE;
         reader_ctl_pkg::PH_ACCESS:
            if (psel && !penable)
               next_phase = reader_ctl_pkg::PH_SETUP;
            else if (!psel)
               next_phase = reader_ctl_pkg::PH_IDLE;
            else
               next_phase = reader_ctl_pkg::PH_ACCESS;
         default:
            next_phase = reader_ctl_pkg::PH_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         phase <= reader_ctl_pkg::PH_IDLE;
      else
         phase <= next_phase;
   end

   // zero-wait slave: access phase always completes
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_hit;
   assign wr_edge = psel && penable && pready && pwrite && addr_hit;
   assign ctl_write = wr_edge && (word_addr == {2'b00, reader_ctl_pkg::IDX_CONTROL});
   assign reload_write = wr_edge && (word_addr == {2'b00, reader_ctl_pkg::IDX_RELOAD});

   // read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= {24'h00_0000, read_mux};
      else if (psel && penable)
         prdata <= prdata;
      else
         prdata <= 32'h0000_0000;
   end

   // standby and deep sleep requests, software owned
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sleep_bits <= reader_ctl_pkg::CONTROL_RST[5:4];
      else if (ctl_write)
         sleep_bits <= {pwdata[reader_ctl_pkg::CTL_STANDBY],
                        pwdata[reader_ctl_pkg::CTL_DEEP]};
   end

   // cipher flag: only the auth result sets it; software may clear; set wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cipher_bit <= reader_ctl_pkg::CONTROL_RST[3];
      else if (auth_second_ok)
         cipher_bit <= 1'b1;
      else if (ctl_write && !pwdata[reader_ctl_pkg::CTL_CIPHER])
         cipher_bit <= 1'b0;
   end

   // control image; reserved and strobe bits hold no state and read as zero
   assign ctl_hold = {2'b00, sleep_bits, cipher_bit, 3'b000};

   assign cipher_active = ctl_hold[reader_ctl_pkg::CTL_CIPHER];

   // power requests; deep sleep implies blocks off as well
   assign power_ctl.blocks_off = ctl_hold[reader_ctl_pkg::CTL_STANDBY] ||
                                 ctl_hold[reader_ctl_pkg::CTL_DEEP];
   assign power_ctl.clock_stop = ctl_hold[reader_ctl_pkg::CTL_DEEP];

   // one-cycle strobes after the write edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         halt_pulse   <= 1'b0;
         launch_pulse <= 1'b0;
         queue_purge  <= 1'b0;
      end
      else
      begin
         halt_pulse   <= ctl_write && pwdata[reader_ctl_pkg::CTL_HALT];
         launch_pulse <= ctl_write && pwdata[reader_ctl_pkg::CTL_LAUNCH];
         queue_purge  <= ctl_write && pwdata[reader_ctl_pkg::CTL_PURGE];
      end
   end

   // timer start value
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reload <= reader_ctl_pkg::RELOAD_RST;
      else if (reload_write)
         reload <= pwdata[7:0];
   end

   // timer; clock stop also freezes it
   timer_unit u_timer
   (
      .pclk    (pclk),
      .presetn (presetn),
      .launch  (launch_pulse),
      .halt    (halt_pulse),
      .freeze  (power_ctl.clock_stop),
      .reload  (reload),
      .count   (timer_count),
      .running (timer_running),
      .expired (timer_expired)
   );

   assign timer_expiry_request = timer_expired;

   // fault set events; collision reported for type A only
   always_comb
   begin
      err_set = 8'h00;
      err_set[reader_ctl_pkg::ERR_KEY] = fault_events.key_format_bad;
      err_set[reader_ctl_pkg::ERR_NVM] = fault_events.nvm_rights_bad;
      err_set[reader_ctl_pkg::ERR_OVR] = fault_events.queue_write_full;
      err_set[reader_ctl_pkg::ERR_CRC] = fault_events.crc_bad &&
                                         receive_check_enable;
      err_set[reader_ctl_pkg::ERR_SOF] = fault_events.sof_bad;
      err_set[reader_ctl_pkg::ERR_PAR] = fault_events.parity_bad;
      err_set[reader_ctl_pkg::ERR_COL] = fault_events.collision_seen &&
                                         !type_b_mode;
   end

   // fault clear events
   always_comb
   begin
      err_clr = 8'h00;
      err_clr[reader_ctl_pkg::ERR_KEY] = fault_events.key_load_start;
      err_clr[reader_ctl_pkg::ERR_NVM] = fault_events.nvm_cmd_start;
      err_clr[reader_ctl_pkg::ERR_OVR] = queue_purge;
      err_clr[reader_ctl_pkg::ERR_CRC] = fault_events.receive_prepare_state;
      err_clr[reader_ctl_pkg::ERR_SOF] = fault_events.receive_prepare_state;
      err_clr[reader_ctl_pkg::ERR_PAR] = fault_events.receive_prepare_state;
      err_clr[reader_ctl_pkg::ERR_COL] = fault_events.receive_prepare_state;
   end

   // sticky error flags of the last command
   fault_flags u_faults
   (
      .pclk    (pclk),
      .presetn (presetn),
      .set_vec (err_set),
      .clr_vec (err_clr),
      .flags   (err_flags)
   );

   // first collision of a frame; rearmed by receive prepare
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         coll_index    <= reader_ctl_pkg::COLL_RST;
         coll_captured <= 1'b0;
      end
      else if (fault_events.collision_seen && !type_b_mode && !coll_captured)
      begin
         coll_index    <= fault_events.collision_pos;
         coll_captured <= 1'b1;
      end
      else if (fault_events.receive_prepare_state)
         coll_captured <= 1'b0;
   end

endmodule

`default_nettype wire

// File: core/reader_ctl_pkg.sv
`default_nettype none
package reader_ctl_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CONTROL = 8'h09;
   localparam logic [7:0] IDX_ERROR   = 8'h0A;
   localparam logic [7:0] IDX_COLL    = 8'h0B;
   localparam logic [7:0] IDX_TIMER   = 8'h0C;
   localparam logic [7:0] IDX_RELOAD  = 8'h10;
   localparam logic [7:0] IDX_TSTAT   = 8'h11;

   // control register fields
   localparam int CTL_STANDBY = 5;
   localparam int CTL_DEEP    = 4;
   localparam int CTL_CIPHER  = 3;
   localparam int CTL_HALT    = 2;
   localparam int CTL_LAUNCH  = 1;
   localparam int CTL_PURGE   = 0;

   // error flag fields
   localparam int ERR_KEY = 6;
   localparam int ERR_NVM = 5;
   localparam int ERR_OVR = 4;
   localparam int ERR_CRC = 3;
   localparam int ERR_SOF = 2;
   localparam int ERR_PAR = 1;
   localparam int ERR_COL = 0;

   // timer status fields
   localparam int TST_EXPIRED = 0;
   localparam int TST_RUNNING = 1;

   // values after reset
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] ERROR_RST   = 8'h40;
   localparam logic [7:0] COLL_RST    = 8'h00;
   localparam logic [7:0] RELOAD_RST  = 8'hFF;
   localparam logic [7:0] COUNT_RST   = 8'h00;

   // timer tick period
   localparam int CLK_PERIOD_NS = 8;
   localparam int TICK_NS       = 128;
   localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);

   // events from the command, receiver and queue logic
   typedef struct packed {
      logic       key_load_start;
      logic       key_format_bad;
      logic       nvm_cmd_start;
      logic       nvm_rights_bad;
      logic       queue_write_full;
      logic       receive_prepare_state;
      logic       crc_bad;
      logic       sof_bad;
      logic       parity_bad;
      logic       collision_seen;
      logic [7:0] collision_pos;
   } fault_events_t;

   // power requests to the analog and clock blocks
   typedef struct packed {
      logic blocks_off;
      logic clock_stop;
   } power_ctl_t;

   typedef enum logic [2:0] {
      PH_IDLE   = 3'b001,
      PH_SETUP  = 3'b010,
      PH_ACCESS = 3'b100
   } apb_phase_t;

endpackage
`default_nettype wire

// File: core/fault_flags.sv
`timescale 1ns/10ps
`default_nettype none

module fault_flags
(
   input  wire logic       pclk,     // clock
   input  wire logic       presetn,  // async reset, low
   input  wire logic [7:0] set_vec,  // per-bit set pulses
   input  wire logic [7:0] clr_vec,  // per-bit clear pulses
   output logic      [7:0] flags     // sticky flags
);

   // one sticky flag per bit; set wins over clear
   genvar i;
   generate
      for (i = 0; i < 8; i++)
      begin : g_flag
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               flags[i] <= reader_ctl_pkg::ERROR_RST[i];
            else if (set_vec[i])
               flags[i] <= 1'b1;
            else if (clr_vec[i])
               flags[i] <= 1'b0;
         end
      end
   endgenerate

endmodule

`default_nettype wire

// File: core/timer_unit.sv
`timescale 1ns/10ps
`default_nettype none

module timer_unit
(
   input  wire logic       pclk,     // clock
   input  wire logic       presetn,  // async reset, low
   input  wire logic       launch,   // start pulse
   input  wire logic       halt,     // stop pulse
   input  wire logic       freeze,   // clock stopped
   input  wire logic [7:0] reload,   // start value
   output logic      [7:0] count,    // current count
   output logic            running,  // counting
   output logic            expired   // reached zero
);

   logic [7:0] tick_cnt;
   logic       tick;

   // divider making the one-cycle tick enable
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tick_cnt <= 8'h00;
      else if (launch || tick)
         tick_cnt <= 8'h00;
      else if (running && !freeze)
         tick_cnt <= tick_cnt + 8'h01;
   end

   assign tick = running && !freeze && (tick_cnt == reader_ctl_pkg::TICK_LAST);

   // down counter; halt wins over launch
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count   <= reader_ctl_pkg::COUNT_RST;
         running <= 1'b0;
         expired <= 1'b0;
      end
      else if (halt)
         running <= 1'b0;
      else if (launch)
      begin
         count   <= reload;
         running <= (reload != 8'h00);
         expired <= (reload == 8'h00);
      end
      else if (tick)
      begin
         count <= count - 8'h01;
         if (count == 8'h01)
         begin
            running <= 1'b0;
            expired <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// File: tb/apb_host.sv
`timescale 1ns/10ps
`default_nettype none

module apb_host
(
   input  wire logic        pclk,    // clock
   input  wire logic        pready,  // slave ready
   input  wire logic [31:0] prdata,  // read data
   input  wire logic        pslverr, // slave error
   output logic             psel,    // select
   output logic             penable, // access phase
   output logic             pwrite,  // direction
   output logic [11:0]      paddr,   // byte address
   output logic [31:0]      pwdata   // write data
);
   // bus idle at time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end

   // one transfer: setup, access until ready, then release
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines show the inverse so stale data cannot pass
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

`default_nettype wire

// File: tb/reader_chk.sv
`timescale 1ns/10ps
`default_nettype none

module reader_chk
(
   input wire logic                       pclk,                 // clock
   input wire logic                       presetn,              // reset, low
   input wire logic                       psel,                 // select
   input wire logic                       penable,              // access
   input wire logic                       pwrite,               // write
   input wire logic [11:0]                paddr,                // address
   input wire logic [31:0]                pwdata,               // write data
   input wire logic [31:0]                prdata,               // read data
   input wire logic                       pslverr,              // error
   input wire logic                       auth_second_ok,       // auth pass
   input wire reader_ctl_pkg::power_ctl_t power_ctl,            // power
   input wire logic                       cipher_active,        // cipher
   input wire logic                       queue_purge,          // purge pulse
   input wire logic                       timer_expiry_request  // expiry
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // access-phase decodes
   wire logic acc = psel && penable;
   wire logic wr_ctl = acc && pwrite && paddr == 12'h024;
   wire logic purge_wr = wr_ctl && pwdata[0];
   wire logic launch_wr = wr_ctl && pwdata[1];
   wire logic mapped = paddr[11:2] inside {10'h09, 10'h0A, 10'h0B, 10'h0C, 10'h10, 10'h11};

   sequence s_one_pulse;
      queue_purge ##1 !queue_purge;
   endsequence

   a_purge_pulse: assert property (purge_wr |=> s_one_pulse)
      else $error("purge pulse missing");
   a_purge_cause: assert property ($rose(queue_purge) |-> $past(purge_wr))
      else $error("purge pulse without write");
   a_standby_on: assert property (wr_ctl && pwdata[5:4] == 2'b10 |=>
      power_ctl.blocks_off && !power_ctl.clock_stop) else $error("standby wrong");
   a_deep_sleep: assert property (wr_ctl && pwdata[4] |=>
      power_ctl.blocks_off && power_ctl.clock_stop) else $error("deep sleep wrong");
   a_power_hold: assert property (!wr_ctl |=> $stable(power_ctl))
      else $error("power changed without write");
   a_cipher_rise: assert property ($rose(cipher_active) |-> $past(auth_second_ok))
      else $error("cipher set without auth");
   a_ctl_read: assert property (acc && !pwrite && paddr == 12'h024 |->
      prdata[31:6] == 26'h0 && prdata[2:0] == 3'h0) else $error("control read bits");
   a_err_read: assert property (acc && !pwrite && paddr == 12'h028 |->
      prdata[31:7] == 25'h0) else $error("error read bits");
   a_expiry_hold: assert property ($fell(timer_expiry_request) |->
      $past(launch_wr, 2) || $past(launch_wr, 3) || $past(launch_wr, 4))
      else $error("expiry dropped without launch");
   a_map_error: assert property (acc |-> pslverr == !mapped)
      else $error("slave error wrong");
endmodule

`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin error_cnt++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, g, x); end end

module testbench;
   logic                          pclk = 1'b0;          // clock
   logic                          presetn = 1'b0;       // reset, low
   wire logic                     psel, penable, pwrite, pready, pslverr;
   wire logic [11:0]              paddr;                // address
   wire logic [31:0]              pwdata, prdata;       // data
   reader_ctl_pkg::fault_events_t fault_events = '0;    // events
   logic                          auth_second_ok = 1'b0;
   logic                          receive_check_enable = 1'b0;
   logic                          type_b_mode = 1'b0;
   reader_ctl_pkg::power_ctl_t    power_ctl;
   wire logic                     cipher_active, queue_purge, timer_expiry_request;
   int                            error_cnt = 0;
   int                            comparisons = 0;

   // 125 MHz clock
   always #4 pclk = ~pclk;

   reader_control_status_page i_reader_control_status_page (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fault_events,
      .auth_second_ok, .receive_check_enable, .type_b_mode, .power_ctl, .cipher_active,
      .queue_purge, .timer_expiry_request);
   apb_host i_apb_host (.pclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite,
      .paddr, .pwdata);

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      i_apb_host.xfer(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      logic e;
      i_apb_host.xfer(1'b0, a, 32'h0, q, e);
   endtask

   // one-cycle event pulse
   task automatic pulse_ev(input reader_ctl_pkg::fault_events_t v, input logic a);
      @(posedge pclk);
      fault_events <= v;
      auth_second_ok <= a;
      @(posedge pclk);
      fault_events <= '0;
      auth_second_ok <= 1'b0;
   endtask

   // expected error flags after one event cycle, set wins
   function automatic logic [7:0] exp_err(logic [7:0] f, reader_ctl_pkg::fault_events_t v,
                                          logic en, logic tb);
      logic [7:0] c;
      logic [7:0] s;
      c = {1'b0, v.key_load_start, v.nvm_cmd_start, 1'b0, {4{v.receive_prepare_state}}};
      s = {1'b0, v.key_format_bad, v.nvm_rights_bad, v.queue_write_full, v.crc_bad & en,
           v.sof_bad, v.parity_bad, v.collision_seen & !tb};
      return (f & ~c) | s;
   endfunction

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // main sequence
   initial
   begin
      logic [11:0]                   ad [5];
      logic [7:0]                    rv [5];
      logic [31:0]                   q;
      logic [7:0]                    d, f, coll, r, c1;
      logic                          e, en, tb, armed;
      reader_ctl_pkg::fault_events_t ev;
      int                            n;
      ad = '{12'h024, 12'h028, 12'h02C, 12'h030, 12'h040};
      rv = '{8'h00, 8'h40, 8'h00, 8'h00, 8'hFF};
      void'($urandom(57448));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         rd(ad[i], q);
         `CHK(q, {24'h0, rv[i]})
         if (i inside {[1:3]})
         begin
            wr(ad[i], $urandom);
            rd(ad[i], q);
            `CHK(q, {24'h0, rv[i]})
         end
      end
      i_apb_host.xfer(1'b0, 12'h034, 32'h0, q, e);
      `CHK({e, q}, 33'h100000000)
      $display("end reset and map");
      for (int i = 0; i < 8; i++)
      begin
         d = (i == 0) ? 8'hFF : 8'($urandom);
         wr(12'h024, {24'h0, d});
         rd(12'h024, q);
         `CHK(q, {24'h0, d & 8'h30})
         `CHK(power_ctl, {d[5] | d[4], d[4]})
      end
      wr(12'h024, 32'h08);
      rd(12'h024, q);
      `CHK(q, 32'h00)
      pulse_ev('0, 1'b1);
      rd(12'h024, q);
      `CHK(q, 32'h08)
      `CHK(cipher_active, 1'b1)
      wr(12'h024, 32'h00);
      rd(12'h024, q);
      `CHK(cipher_active, 1'b0)
      $display("end control");
      f = 8'h40;
      coll = 8'h00;
      armed = 1'b1;
      for (int i = 0; i < 48; i++)
      begin
         ev = {(i == 0) ? 10'h3FF : 10'($urandom & $urandom & $urandom), 8'($urandom % 9)};
         if (ev.receive_prepare_state)
            ev.collision_seen = 1'b0;
         en = 1'($urandom);
         tb = 1'($urandom);
         receive_check_enable <= en;
         type_b_mode <= tb;
         pulse_ev(ev, 1'b0);
         f = exp_err(f, ev, en, tb);
         if (ev.receive_prepare_state)
            armed = 1'b1;
         else if (ev.collision_seen && !tb && armed)
         begin
            coll = ev.collision_pos;
            armed = 1'b0;
         end
         if (i % 5 == 4)
         begin
            wr(12'h024, 32'h01);
            f[4] = 1'b0;
         end
         rd(12'h028, q);
         `CHK(q, {24'h0, f})
         rd(12'h02C, q);
         `CHK(q, {24'h0, coll})
      end
      $display("end fault flags");
      r = 8'(2 + $urandom % 4);
      wr(12'h040, {24'h0, r});
      wr(12'h024, 32'h02);
      rd(12'h044, q);
      `CHK(q, 32'h02)
      for (n = 0; n < 2000 && timer_expiry_request !== 1'b1; n++)
         @(posedge pclk);
      `CHK(timer_expiry_request, 1'b1)
      `CHK(n >= (r - 1) * 16, 1'b1)
      rd(12'h030, q);
      `CHK(q, 32'h0)
      rd(12'h044, q);
      `CHK(q, 32'h01)
      wr(12'h040, 32'hFF);
      wr(12'h024, 32'h02);
      repeat (40) @(posedge pclk);
      wr(12'h024, 32'h04);
      rd(12'h030, q);
      c1 = q[7:0];
      repeat (64) @(posedge pclk);
      rd(12'h030, q);
      `CHK(q[7:0], c1)
      `CHK(c1 < 8'hFF, 1'b1)
      rd(12'h044, q);
      `CHK(q, 32'h00)
      $display("end timer");
      wrap_up();
   end

   // watchdog against a hung handshake
   initial
   begin
      repeat (30000) @(posedge pclk);
      error_cnt++;
      wrap_up();
   end
endmodule

bind reader_control_status_page reader_chk i_reader_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pslverr, .auth_second_ok, .power_ctl, .cipher_active,
   .queue_purge, .timer_expiry_request);

`undef CHK
`default_nettype wire
